/* hdl/srp_regs.svh */
`ifndef SRP_REGS_SVH
`define SRP_REGS_SVH

// register offsets (byte addresses on the plain register port)
`define SRP_ADDR_CFG      4'h0
`define SRP_ADDR_STAT     4'h4

// config register field positions
`define SRP_CFG_WIDTH_LSB 0
`define SRP_CFG_WIDTH_MSB 2
`define SRP_CFG_CLK_LSB   4
`define SRP_CFG_CLK_MSB   5
`define SRP_CFG_DDR_BIT   8

// status register field positions
`define SRP_STAT_FULL_LSB  0
`define SRP_STAT_EMPTY_LSB 4

// reset values
`define SRP_WIDTH_RST     3'h4
`define SRP_CLK_RST       2'h0
`define SRP_DDR_RST       1'b0

// width select codes
`define SRP_WIDTH_8       3'h0
`define SRP_WIDTH_16      3'h1
`define SRP_WIDTH_24      3'h2
`define SRP_WIDTH_32      3'h3
`define SRP_WIDTH_40      3'h4

// clock select codes
`define SRP_CLK_SEL_LOW   2'h0
`define SRP_CLK_SEL_MID   2'h1
`define SRP_CLK_SEL_HIGH  2'h2

// result clock rates in MHz, normal mode
`define SRP_RCLK_MAX_MHZ  300
`define SRP_RCLK_LOW_MHZ  75
`define SRP_RCLK_MID_MHZ  150
`define SRP_RCLK_HIGH_MHZ 300

// half periods in system cycles, scaled so the fastest rate is one cycle
`define SRP_HALF_LOW      4'((`SRP_RCLK_MAX_MHZ / `SRP_RCLK_LOW_MHZ))
`define SRP_HALF_MID      4'((`SRP_RCLK_MAX_MHZ / `SRP_RCLK_MID_MHZ))
`define SRP_HALF_HIGH     4'((`SRP_RCLK_MAX_MHZ / `SRP_RCLK_HIGH_MHZ))

// buffer and frame figures
`define SRP_FIFO_DEPTH    15
`define SRP_STAMP_W       40
`define SRP_GAP_BITS      6'h02
`define SRP_TAG_VAL       1'b1

`endif

/* hdl/srp_pkg.sv */
package srp_pkg;

  // frame phase of the shared serial sequencer
  typedef enum logic [1:0] {
    SRP_PH_TAG  = 2'b00,
    SRP_PH_DATA = 2'b01,
    SRP_PH_GAP  = 2'b10
  } srp_phase_e;

  // software configuration
  typedef struct packed {
    logic       ddr;
    logic [1:0] clk_sel;
    logic [2:0] width_sel;
  } srp_cfg_s;

  typedef logic [39:0] srp_stamp_t;

endpackage

/* hdl/srp_fifo_if.sv */
`timescale 1ns/1ps
`include "srp_regs.svh"

// push side from capture, pop side from the serial sequencer
interface srp_fifo_if;
  logic                    push;
  logic [`SRP_STAMP_W-1:0] push_data;
  logic                    pop;
  logic [`SRP_STAMP_W-1:0] head;
  logic                    full;
  logic                    empty;

  modport fifo (input push, input push_data, input pop, output head, output full, output empty);
  modport user (output push, output push_data, output pop, input head, input full, input empty);
endinterface

/* hdl/srp_fifo.sv */
`timescale 1ns/1ps
`include "srp_regs.svh"

module srp_fifo (
  // clock and reset
  input  wire logic sys_clk_in,
  input  wire logic rst_in,
  // buffer port
  srp_fifo_if.fifo  bus
);

  logic [`SRP_STAMP_W-1:0] mem [`SRP_FIFO_DEPTH];  // stamp storage
  logic [3:0]              wr_ptr_r;                // next free slot
  logic [3:0]              rd_ptr_r;                // oldest entry
  logic [3:0]              count_r;                 // entries held
  logic                    do_push;                 // accepted write
  logic                    do_pop;                  // accepted read

  // a stamp that meets a full buffer is simply dropped
  assign do_push = bus.push && (count_r != 4'(`SRP_FIFO_DEPTH));
  assign do_pop  = bus.pop && (count_r != 4'h0);

  // show-ahead head so the arithmetic stage sees it without delay
  assign bus.head  = mem[rd_ptr_r];
  assign bus.full  = (count_r == 4'(`SRP_FIFO_DEPTH));
  assign bus.empty = (count_r == 4'h0);

  // storage write, no reset needed on data
  always_ff @(posedge sys_clk_in) begin
    if (do_push) begin
      mem[wr_ptr_r] <= bus.push_data;
    end
  end

  // pointers and occupancy
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_ptr_r <= 4'h0;
      rd_ptr_r <= 4'h0;
      count_r  <= 4'h0;
    end else begin
      if (do_push) begin
        wr_ptr_r <= (wr_ptr_r == 4'(`SRP_FIFO_DEPTH - 1)) ? 4'h0 : wr_ptr_r + 4'h1;
      end
      if (do_pop) begin
        rd_ptr_r <= (rd_ptr_r == 4'(`SRP_FIFO_DEPTH - 1)) ? 4'h0 : rd_ptr_r + 4'h1;
      end
      count_r <= count_r + {3'h0, do_push} - {3'h0, do_pop};
    end
  end

endmodule

/* hdl/srp_top.sv */
`timescale 1ns/1ps
`include "srp_regs.svh"

module srp_top (
  // clock and reset
  input  wire logic                sys_clk_in,
  input  wire logic                rst_in,
  // register port
  input  wire logic [3:0]          reg_addr_in,
  input  wire logic [31:0]         reg_wdata_in,
  input  wire logic                reg_wr_in,
  input  wire logic                reg_rd_in,
  output logic      [31:0]         reg_rdata_out,
  // stamp capture, same clock domain
  input  wire logic [3:0]          stamp_valid_in,
  input  wire logic [3:0][39:0]    stamp_data_in,
  input  wire logic [39:0]         sync_stamp_in,
  input  wire logic [3:0][39:0]    cal_in,
  // serial result port
  output logic                     rclk_out,
  output logic      [3:0]          result_strobe_n_out,
  output logic      [3:0]          result_data_out
);

  ////////////////////////////////////////////////////////////////////////
  // declarations

  // config and sequencer state; all pins below come from flip-flops
  srp_pkg::srp_cfg_s     cfg_r;        // software configuration
  srp_pkg::srp_phase_e   phase_r;      // current frame phase
  srp_pkg::srp_phase_e   phase_nxt;    // phase after the next bit tick
  logic [5:0]            idx_r;        // bit index inside phase
  logic [5:0]            idx_nxt;      // index after the next bit tick
  logic [5:0]            n_r;          // width latched for this frame
  logic [3:0]            hcnt_r;       // half-period counter
  logic [3:0]            half_base;    // half period before ddr doubling
  logic [3:0]            half_lim;     // half period for current setting
  logic                  toggle;       // result clock flips this cycle
  logic                  bit_tick;     // serial data moves this cycle
  logic                  load;         // free-running load pulse
  logic [3:0]            active_r;     // channel carries a result
  srp_pkg::srp_stamp_t   shift_r [4];  // result being sent per channel
  srp_pkg::srp_stamp_t   head_c  [4];  // buffer heads
  srp_pkg::srp_stamp_t   res_c   [4];  // arithmetic stage outputs
  logic [3:0]            full_c;       // buffer full flags
  logic [3:0]            empty_c;      // buffer empty flags
  logic [3:0]            pop_c;        // buffer reads

  ////////////////////////////////////////////////////////////////////////
  // decode helpers

  // unused width codes never reach here, the config write maps them
  // word width in bits for a width code
  function automatic logic [5:0] srp_width(input logic [2:0] code);
    logic [5:0] w;
    w = 6'h28;
    unique case (code)
      `SRP_WIDTH_8:  w = 6'h08;
      `SRP_WIDTH_16: w = 6'h10;
      `SRP_WIDTH_24: w = 6'h18;
      `SRP_WIDTH_32: w = 6'h20;
      default:       w = 6'h28;
    endcase
    return w;
  endfunction

  // code 11 cannot be stored, it is caught at the config write
  // half period in system cycles for a clock code
  function automatic logic [3:0] srp_half(input logic [1:0] code);
    logic [3:0] h;
    h = `SRP_HALF_LOW;
    unique case (code)
      `SRP_CLK_SEL_MID:  h = `SRP_HALF_MID;
      `SRP_CLK_SEL_HIGH: h = `SRP_HALF_HIGH;
      default:           h = `SRP_HALF_LOW;
    endcase
    return h;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // channel buffers and arithmetic stage

  // one interface per channel keeps the push and pop wires together
  // capture pushes at system rate, the sequencer pops far slower
  srp_fifo_if fifo_bus [4] ();

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_ch
      // capture side feeds the buffer straight in
      assign fifo_bus[g].push      = stamp_valid_in[g];
      assign fifo_bus[g].push_data = stamp_data_in[g];
      assign fifo_bus[g].pop       = pop_c[g];
      assign head_c[g]             = fifo_bus[g].head;
      assign full_c[g]             = fifo_bus[g].full;
      assign empty_c[g]            = fifo_bus[g].empty;

      // an empty buffer is never popped, so its pointers cannot slip
      // a read happens only on the load pulse of the transmitter
      assign pop_c[g] = load && !fifo_bus[g].empty;

      // sync and correction are sampled live at the load edge, so a sync
      // that moves while a stamp waits gives a negative result instead
      // event minus sync plus correction, modulo forty bits
      assign res_c[g] = head_c[g] - sync_stamp_in + cal_in[g];

      // fifteen deep: a slow result rate can absorb a short burst only
      srp_fifo u_fifo (
        .sys_clk_in (sys_clk_in),
        .rst_in     (rst_in),
        .bus        (fifo_bus[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // register port

  // software sees one config word and one live status word; the
  // slave answers every strobe at once, so no wait logic is needed
  // config writes; reserved codes fall back to the reset setting
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cfg_r.width_sel <= `SRP_WIDTH_RST;
      cfg_r.clk_sel   <= `SRP_CLK_RST;
      cfg_r.ddr       <= `SRP_DDR_RST;
    end else if (reg_wr_in && reg_addr_in == `SRP_ADDR_CFG) begin
      // width codes above forty bits are unused
      if (reg_wdata_in[`SRP_CFG_WIDTH_MSB:`SRP_CFG_WIDTH_LSB] > `SRP_WIDTH_40) begin
        cfg_r.width_sel <= `SRP_WIDTH_RST;
      end else begin
        cfg_r.width_sel <= reg_wdata_in[`SRP_CFG_WIDTH_MSB:`SRP_CFG_WIDTH_LSB];
      end
      // the top clock code is unused
      if (reg_wdata_in[`SRP_CFG_CLK_MSB:`SRP_CFG_CLK_LSB] > `SRP_CLK_SEL_HIGH) begin
        cfg_r.clk_sel <= `SRP_CLK_RST;
      end else begin
        cfg_r.clk_sel <= reg_wdata_in[`SRP_CFG_CLK_MSB:`SRP_CFG_CLK_LSB];
      end
      cfg_r.ddr <= reg_wdata_in[`SRP_CFG_DDR_BIT];
    end
  end

  // status bits are live flags, nothing here is sticky or cleared
  // read data stands one cycle after the strobe, zero otherwise
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      reg_rdata_out <= 32'h0000_0000;
    end else begin
      reg_rdata_out <= 32'h0000_0000;
      if (reg_rd_in) begin
        unique case (reg_addr_in)
          `SRP_ADDR_CFG: begin
            reg_rdata_out[`SRP_CFG_WIDTH_MSB:`SRP_CFG_WIDTH_LSB] <= cfg_r.width_sel;
            reg_rdata_out[`SRP_CFG_CLK_MSB:`SRP_CFG_CLK_LSB]     <= cfg_r.clk_sel;
            reg_rdata_out[`SRP_CFG_DDR_BIT]                      <= cfg_r.ddr;
          end
          `SRP_ADDR_STAT: begin
            reg_rdata_out[`SRP_STAT_FULL_LSB +: 4]  <= full_c;
            reg_rdata_out[`SRP_STAT_EMPTY_LSB +: 4] <= empty_c;
          end
          // unmapped addresses read as zero
          default: reg_rdata_out <= 32'h0000_0000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // result clock generator

  // half period for the selected rate, decoded once
  assign half_base = srp_half(cfg_r.clk_sel);
  // double rate keeps the bit time by doubling the half period
  assign half_lim = cfg_r.ddr ? {half_base[2:0], 1'b0} : half_base;
  // >= so that a rate change mid-count cannot run past the limit
  assign toggle   = (hcnt_r + 4'h1 >= half_lim);
  // normal mode moves data with the rising edge only; ddr with both
  // the receiver then sees each bit stand a full bit time
  assign bit_tick = toggle && (cfg_r.ddr || !rclk_out);

  // the clock is a plain register: no gating, so it stays glitch free
  // rates are scaled to the system clock, fastest is one cycle per half
  // divider from the system clock, result clock is a register
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      hcnt_r   <= 4'h0;
      rclk_out <= 1'b0;
    end else if (toggle) begin
      hcnt_r   <= 4'h0;
      rclk_out <= !rclk_out;
    end else begin
      hcnt_r <= hcnt_r + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // frame sequencer, shared by all four channels

  // one sequencer serves all four channels, so every frame starts on
  // the same tick; idle channels just keep their strobe high meanwhile
  // frame = tag + width + two gap slots, all counted in bit ticks
  // next phase and index, taken only on a bit tick
  always_comb begin
    phase_nxt = phase_r;
    idx_nxt   = idx_r;
    unique case (phase_r)
      srp_pkg::SRP_PH_TAG: begin
        phase_nxt = srp_pkg::SRP_PH_DATA;
        idx_nxt   = 6'h00;
      end
      srp_pkg::SRP_PH_DATA: begin
        if (idx_r == n_r - 6'h01) begin
          phase_nxt = srp_pkg::SRP_PH_GAP;
          idx_nxt   = 6'h00;
        end else begin
          idx_nxt = idx_r + 6'h01;
        end
      end
      srp_pkg::SRP_PH_GAP: begin
        if (idx_r == `SRP_GAP_BITS - 6'h01) begin
          phase_nxt = srp_pkg::SRP_PH_TAG;
          idx_nxt   = 6'h00;
        end else begin
          idx_nxt = idx_r + 6'h01;
        end
      end
      default: begin
        phase_nxt = srp_pkg::SRP_PH_GAP;
        idx_nxt   = 6'h00;
      end
    endcase
  end

  // the load is free running, so latency depends on where a stamp
  // lands in the current frame: up to one full frame of waiting
  // load pulse: once per frame, free running whether data waits or not
  assign load = bit_tick && (phase_nxt == srp_pkg::SRP_PH_TAG);

  // a width write lands between frames, never inside one
  // phase, index and frame width
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      // start at the last gap bit so the first tick loads
      phase_r <= srp_pkg::SRP_PH_GAP;
      idx_r   <= `SRP_GAP_BITS - 6'h01;
      n_r     <= 6'h28;
    end else if (bit_tick) begin
      phase_r <= phase_nxt;
      idx_r   <= idx_nxt;
      // width held for the whole frame, so a write never tears a word
      if (load) begin
        n_r <= srp_width(cfg_r.width_sel);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // per-channel shift and pins

  // shift_r holds the whole forty-bit result; narrower words just stop
  // early and take the sign from bit 39, so the sign is never lost
  // result capture on the load pulse; sync is sampled right here
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      active_r <= 4'h0;
      for (int c = 0; c < 4; c++) begin
        shift_r[c] <= 40'h00_0000_0000;
      end
    end else if (load) begin
      for (int c = 0; c < 4; c++) begin
        active_r[c] <= !empty_c[c];
        if (!empty_c[c]) begin
          shift_r[c] <= res_c[c];
        end
      end
    end
  end

  // phase_nxt is used so pins and phase move on the very same tick
  // and the strobe never lags the data it frames
  // strobe and data pins, moved only on a bit tick
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      result_strobe_n_out <= 4'hF;
      result_data_out     <= 4'h0;
    end else if (bit_tick) begin
      for (int c = 0; c < 4; c++) begin
        unique case (phase_nxt)
          srp_pkg::SRP_PH_TAG: begin
            // a channel with a waiting stamp opens its frame
            if (!empty_c[c]) begin
              result_strobe_n_out[c] <= 1'b0;
              result_data_out[c]     <= `SRP_TAG_VAL;
            end else begin
              result_strobe_n_out[c] <= 1'b1;
              result_data_out[c]     <= 1'b0;
            end
          end
          srp_pkg::SRP_PH_DATA: begin
            if (active_r[c]) begin
              // the last slot carries the true sign of the full result
              if (idx_nxt == n_r - 6'h01) begin
                result_data_out[c] <= shift_r[c][39];
              end else begin
                result_data_out[c] <= shift_r[c][idx_nxt];
              end
            end else begin
              result_data_out[c] <= 1'b0;
            end
          end
          default: begin
            // end-of-word marker, also the idle level
            result_strobe_n_out[c] <= 1'b1;
            result_data_out[c]     <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule

/* test/srp_top_asserts.sv */
`timescale 1ns/1ps
`include "srp_regs.svh"

module srp_top_asserts (
  // clock and reset
  input wire logic        sys_clk_in,
  input wire logic        rst_in,
  // register port
  input wire logic [3:0]  reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic        reg_wr_in,
  input wire logic        reg_rd_in,
  input wire logic [31:0] reg_rdata_out,
  // serial result port
  input wire logic        rclk_out,
  input wire logic [3:0]  result_strobe_n_out,
  input wire logic [3:0]  result_data_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  ////////////////////////////////////////////////////////////
  logic [2:0] wid_r;    // shadow width code
  logic [1:0] ck_r;     // shadow clock code
  logic       ddr_r;    // shadow double rate enable
  logic [5:0] settle_r; // cycles since config write, clock may realign meanwhile
  logic       rclk_q_r; // result clock one cycle back
  logic [3:0] hc_r;     // cycles since last clock toggle
  logic [7:0] hi_r;     // channel 1 strobe high run, saturating; sees back-to-back frames
  logic [9:0] lo_r;     // channel 0 strobe low run
  int         half_c;   // clock half period, normal mode
  int         bits_c;   // selected word width
  assign half_c = (ck_r == `SRP_CLK_SEL_LOW) ? 4 : (ck_r == `SRP_CLK_SEL_MID) ? 2 : 1;
  assign bits_c = 8 * (int'(wid_r) + 1);

  // config shadow, reserved codes fall back to the defaults
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      wid_r <= `SRP_WIDTH_RST;
      ck_r <= `SRP_CLK_RST;
      ddr_r <= `SRP_DDR_RST;
      settle_r <= 6'h00;
    end else if (reg_wr_in && reg_addr_in == `SRP_ADDR_CFG) begin
      wid_r <= (reg_wdata_in[2:0] > `SRP_WIDTH_40) ? `SRP_WIDTH_40 : reg_wdata_in[2:0];
      ck_r <= (reg_wdata_in[5:4] == 2'h3) ? `SRP_CLK_RST : reg_wdata_in[5:4];
      ddr_r <= reg_wdata_in[8];
      settle_r <= 6'h00;
    end else if (!settle_r[5]) begin
      settle_r <= settle_r + 6'h01;
    end
  end

  // run lengths of clock phases, channel 1 strobe high, channel 0 strobe low
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rclk_q_r <= 1'b0;
      hc_r <= 4'h0;
      hi_r <= 8'hFF;
      lo_r <= 10'h000;
    end else begin
      rclk_q_r <= rclk_out;
      hc_r <= (rclk_out != rclk_q_r) ? 4'h0 : hc_r + 4'h1;
      hi_r <= !result_strobe_n_out[1] ? 8'h00 : (hi_r == 8'hFF) ? hi_r : hi_r + 8'h01;
      lo_r <= result_strobe_n_out[0] ? 10'h000 : lo_r + 10'h001;
    end
  end
  ////////////////////////////////////////////////////////////
  property p_idle; (result_data_out & result_strobe_n_out) == 4'h0; endproperty
  a_idle: assert property (p_idle) else $error("data active outside a frame");
  property p_tag; ((~result_strobe_n_out & $past(result_strobe_n_out)) & ~result_data_out) == 4'h0;
  endproperty
  a_tag: assert property (p_tag) else $error("frame start without tag bit");
  property p_norm; !ddr_r && settle_r[5] && $changed(result_data_out) |-> $rose(rclk_out);
  endproperty
  a_norm: assert property (p_norm) else $error("data moved off rising clock");
  property p_ddr; ddr_r && settle_r[5] && $changed(result_data_out) |-> $changed(rclk_out);
  endproperty
  a_ddr: assert property (p_ddr) else $error("data moved off clock edge");
  property p_half; $changed(rclk_out) && settle_r[5] |-> hc_r == half_c * (ddr_r ? 2 : 1) - 1;
  endproperty
  a_half: assert property (p_half) else $error("result clock rate wrong");
  property p_gap; $fell(result_strobe_n_out[1]) |-> hi_r >= 4 * half_c; endproperty
  a_gap: assert property (p_gap) else $error("end gap too short");
  property p_len; $rose(result_strobe_n_out[0]) && settle_r[5] |-> lo_r == (bits_c + 1) * 2 * half_c;
  endproperty
  a_len: assert property (p_len) else $error("frame length wrong");
  property p_cfg; $past(reg_rd_in) && $past(reg_addr_in) == `SRP_ADDR_CFG
    |-> reg_rdata_out == {23'h0, ddr_r, 2'h0, ck_r, 1'b0, wid_r}; endproperty
  a_cfg: assert property (p_cfg) else $error("config readback wrong");
endmodule

bind srp_top srp_top_asserts srp_top_asserts_i (.sys_clk_in, .rst_in, .reg_addr_in,
  .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .rclk_out, .result_strobe_n_out,
  .result_data_out);

/* test/srp_rx_model.sv */
`timescale 1ns/1ps

// receiving logic: gathers each frame, tag in bit 0
module srp_rx_model (
  // clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        rst_in,
  // link side
  input  wire logic        ddr_in,
  input  wire logic        rclk_in,
  input  wire logic [3:0]  strobe_n_in,
  input  wire logic [3:0]  data_in,
  // gathered frames
  output logic [3:0][40:0] word_out,
  output logic [3:0][6:0]  len_out,
  output logic [3:0]       done_out,
  output logic [3:0][7:0]  count_out
);
  logic             rclk_q_r; // clock one cycle back
  logic [3:0]       stb_q_r;  // strobe held before the edge
  logic [3:0]       dat_q_r;  // data held before the edge
  logic [3:0][40:0] shift_r;  // bits so far
  logic [3:0][6:0]  nbit_r;   // count of bits so far
  logic             tick;     // sampling edge
  // normal mode samples rising edges, double rate both edges
  assign tick = ddr_in ? (rclk_in != rclk_q_r) : (rclk_in && !rclk_q_r);

  // values from before the edge: the bit launched one edge earlier
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rclk_q_r <= 1'b0;
      stb_q_r <= 4'hF;
      dat_q_r <= 4'h0;
      shift_r <= '0;
      nbit_r <= '0;
      word_out <= '0;
      len_out <= '0;
      done_out <= 4'h0;
      count_out <= '0;
    end else begin
      rclk_q_r <= rclk_in;
      stb_q_r <= strobe_n_in;
      dat_q_r <= data_in;
      done_out <= 4'h0;
      for (int c = 0; c < 4; c++) begin
        if (tick && !stb_q_r[c]) begin
          shift_r[c][nbit_r[c]] <= dat_q_r[c];
          nbit_r[c] <= nbit_r[c] + 7'h01;
        end else if (tick && nbit_r[c] != 7'h00) begin
          word_out[c] <= shift_r[c];
          len_out[c] <= nbit_r[c];
          done_out[c] <= 1'b1;
          count_out[c] <= count_out[c] + 8'h01;
          nbit_r[c] <= 7'h00;
          shift_r[c] <= '0;
        end
      end
    end
  end
endmodule

/* test/tb.sv */
`timescale 1ns/1ps
`include "srp_regs.svh"

module tb;
  logic             clk, rst, wr, rd, rx_ddr, rclk;
  logic [3:0]       addr, sv, stb_n, dat, rx_done;
  logic [31:0]      wdata, rdata, v;
  logic [3:0][39:0] sd, cal;
  logic [39:0]      sync, s;
  logic [3:0][40:0] rx_word;
  logic [3:0][6:0]  rx_len;
  logic [3:0][7:0]  rx_cnt;
  int               miscompares, tests_run, n, i, k, d;

  srp_top srp_top_i (.sys_clk_in(clk), .rst_in(rst), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .stamp_valid_in(sv),
    .stamp_data_in(sd), .sync_stamp_in(sync), .cal_in(cal), .rclk_out(rclk),
    .result_strobe_n_out(stb_n), .result_data_out(dat));
  srp_rx_model srp_rx_model_i (.sys_clk_in(clk), .rst_in(rst), .ddr_in(rx_ddr), .rclk_in(rclk),
    .strobe_n_in(stb_n), .data_in(dat), .word_out(rx_word), .len_out(rx_len),
    .done_out(rx_done), .count_out(rx_cnt));
  ////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic chk(input logic [40:0] seen, input logic [40:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [31:0] w);
    @(posedge clk);
    addr <= a;
    wdata <= w;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] q);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 q = rdata;
  endtask

  // config write, then let the result clock settle before traffic
  task automatic cfg(input logic [2:0] w, input logic [1:0] c, input logic dd);
    wr_reg(`SRP_ADDR_CFG, {23'h0, dd, 2'h0, c, 1'b0, w});
    rx_ddr <= dd;
    repeat (40) @(posedge clk);
  endtask

  task automatic push(input logic [3:0] m, input logic [39:0] st);
    @(posedge clk);
    sv <= m;
    sd <= {4{st}};
    @(posedge clk);
    sv <= 4'h0;
  endtask

  // tag, low bits upward, sign last
  function automatic logic [40:0] frame(input logic [39:0] r, input int nb);
    frame = 41'h0;
    frame[0] = 1'b1;
    for (int b = 0; b < nb - 1; b++) frame[b + 1] = r[b];
    frame[nb] = r[39];
  endfunction

  // waits for a frame on one channel, checks length and content
  task automatic get(input int c, input logic [39:0] st, input int nb);
    int t;
    for (t = 0; t < 4000 && rx_done[c] !== 1'b1; t++) @(posedge clk);
    chk(41'(rx_done[c]), 41'h1);
    chk(41'(rx_len[c]), 41'(nb + 1));
    chk(rx_word[c], frame(st - sync + cal[c], nb));
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wdata = 32'h0;
    sv = 4'h0;
    rx_ddr = 1'b0;
    sd = '0;
    sync = 40'h0000001000;
    cal = {40'h0000000000, 40'hFFFFFFF000, 40'h0000000123, 40'h0000000005};
    miscompares = 0;
    tests_run = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    // defaults, reserved codes, unmapped place
    rd_reg(`SRP_ADDR_CFG, v); chk(41'(v), 41'h004);
    rd_reg(`SRP_ADDR_STAT, v); chk(41'(v), 41'h0F0);
    rd_reg(4'h8, v); chk(41'(v), 41'h000);
    wr_reg(`SRP_ADDR_CFG, 32'h00000037);
    rd_reg(`SRP_ADDR_CFG, v); chk(41'(v), 41'h004);
    $display("test registers done");
    // every width code, one positive and one negative result
    for (k = 0; k < 5; k++) begin
      cfg(3'(k), `SRP_CLK_SEL_HIGH, 1'b0);
      s = 40'h0000001800 + 40'(k) * 40'h111;
      push(4'h5, s);
      get(0, s, 8 * (k + 1));
      get(2, s, 8 * (k + 1));
    end
    $display("test widths done");
    // every clock code in both modes
    for (k = 0; k < 3; k++) begin
      for (d = 0; d < 2; d++) begin
        cfg(`SRP_WIDTH_16, 2'(k), 1'(d));
        v = {31'h0, rclk};
        for (n = 0; n < 40 && rclk === v[0]; n++) @(posedge clk);
        v[0] = rclk;
        for (n = 0; n < 40 && rclk === v[0]; n++) @(posedge clk);
        chk(41'(n), 41'((4 >> k) * (d + 1)));
        s = 40'h00000020AB + 40'(k);
        push(4'h8, s);
        get(3, s, 16);
      end
    end
    $display("test clocks done");
    // overfill one buffer just after a load, then drain it
    cfg(`SRP_WIDTH_40, `SRP_CLK_SEL_LOW, 1'b0);
    push(4'h1, 40'h0000000777);
    for (n = 0; n < 1000 && stb_n[0] !== 1'b0; n++) @(posedge clk);
    for (i = 0; i < 17; i++) begin
      sv <= 4'h2;
      sd <= {4{40'h0010000000 + 40'(i)}};
      @(posedge clk);
    end
    sv <= 4'h0;
    rd_reg(`SRP_ADDR_STAT, v); chk(41'(v), 41'h0D2);
    for (i = 0; i < 15; i++) begin
      @(posedge clk);
      get(1, 40'h0010000000 + 40'(i), 40);
    end
    rd_reg(`SRP_ADDR_STAT, v); chk(41'(v), 41'h0F0);
    chk(41'(rx_cnt), 41'({8'h06, 8'h05, 8'h0F, 8'h06}));
    $display("test buffer done");
    end_sim();
  end

  // hang guard, about four times the expected run
  initial begin
    #600000;
    miscompares++;
    end_sim();
  end
endmodule
